// [pkg/syc_pkg.sv]
// Purpose: Shared constants and types for the synchrocheck supervision block
// Assumes: 100 MHz clock, APB register access with 32-bit data
// Notes:   Magnitudes in 0.01 %Un, frequencies in 0.01 Hz, angles in 0.01 deg
`default_nettype none
package syc_pkg;
    // Register byte offsets
    localparam logic [7:0] SYC_OFF_CTRL     = 8'h00;
    localparam logic [7:0] SYC_OFF_LIM_MAG  = 8'h04;
    localparam logic [7:0] SYC_OFF_LIM_ANG  = 8'h08;
    localparam logic [7:0] SYC_OFF_LIM_FRQ  = 8'h0c;
    localparam logic [7:0] SYC_OFF_THRESH   = 8'h10;
    localparam logic [7:0] SYC_OFF_VCOND    = 8'h14;
    localparam logic [7:0] SYC_OFF_BRKDLY   = 8'h18;
    localparam logic [7:0] SYC_OFF_STATE    = 8'h1c;
    localparam logic [7:0] SYC_OFF_VSTAT    = 8'h20;
    localparam logic [7:0] SYC_OFF_MAGDIFF  = 8'h24;
    localparam logic [7:0] SYC_OFF_ANGDIFF  = 8'h28;
    localparam logic [7:0] SYC_OFF_FRQDIFF  = 8'h2c;
    localparam logic [7:0] SYC_OFF_PLACE    = 8'h30;

    // Control, threshold and voltage status register field positions
    localparam int SYC_CTRL_SS3      = 0;
    localparam int SYC_CTRL_SS4      = 1;
    localparam int SYC_CTRL_USE      = 2;   // 3 bits, one per stage
    localparam int SYC_CTRL_ONSTART  = 5;   // 3 bits, one per stage
    localparam int SYC_CTRL_AUTO     = 8;
    localparam int SYC_CTRL_REF1     = 9;   // 3 bits
    localparam int SYC_CTRL_REF2     = 12;  // 3 bits
    localparam int SYC_CTRL_REF3     = 15;
    localparam int SYC_CTRL_DSEL     = 16;  // 2 bits
    localparam int SYC_THR_DEAD      = 16;
    localparam int SYC_VSTAT_SW      = 12;

    // State report bit positions
    localparam int SYC_ST_BLOCKED    = 0;
    localparam int SYC_ST_OK         = 1;
    localparam int SYC_ST_BYPASS     = 2;
    localparam int SYC_ST_VCOND      = 3;
    localparam int SYC_ST_MAG        = 4;
    localparam int SYC_ST_ANG        = 5;
    localparam int SYC_ST_FRQ        = 6;

    // Reset values
    localparam logic [31:0] SYC_RST_CTRL   = 32'h0000_0000;
    localparam logic [15:0] SYC_RST_LIM    = 16'h0000;
    localparam logic [31:0] SYC_RST_THRESH = 32'h0000_0000;
    localparam logic [11:0] SYC_RST_VCOND  = 12'h000;
    localparam logic [15:0] SYC_RST_BRKDLY = 16'h000a;   // 10 steps of 5 ms

    // Timing: one processing cycle per measurement refresh
    localparam int SYC_TIME_BASE_NS  = 5000000;
    localparam int SYC_CLK_PERIOD_NS = 10;
    localparam int SYC_TICK_CYCLES   = SYC_TIME_BASE_NS / SYC_CLK_PERIOD_NS;
    // Slip per 5 ms step per 0.01 Hz, in 0.001 deg: 0.01*360*0.005*1000
    localparam int SYC_SLIP_MDEG     = 18;
    localparam int SYC_FULL_TURN     = 36000;
    localparam int SYC_HALF_TURN     = 18000;
    localparam int SYC_PLACE_SCALE   = 10;

    typedef enum logic [2:0] {
        SYC_REF_NONE = 3'b000,
        SYC_REF_AB   = 3'b001,
        SYC_REF_BC   = 3'b010,
        SYC_REF_CA   = 3'b011,
        SYC_REF_A    = 3'b100,
        SYC_REF_B    = 3'b101,
        SYC_REF_C    = 3'b110
    } syc_ref_t;

    typedef enum logic [2:0] {
        SYC_VS_NONE  = 3'b000,
        SYC_VS_DD    = 3'b001,
        SYC_VS_LD    = 3'b010,
        SYC_VS_DL    = 3'b011,
        SYC_VS_LL    = 3'b100,
        SYC_VS_UNDEF = 3'b101
    } syc_vstat_t;

    typedef enum logic [1:0] {
        SYC_SW_OFF   = 2'b00,
        SYC_SW_STILL = 2'b01,
        SYC_SW_DEP   = 2'b10,
        SYC_SW_ENC   = 2'b11
    } syc_sw_t;

    typedef struct packed {
        logic [15:0] mag;   // 0.01 %Un
        logic [15:0] frq;   // 0.01 Hz
        logic [15:0] ang;   // 0.01 deg, 0..35999
    } syc_meas_t;
endpackage
`default_nettype wire

// [hdl/syc_top.sv]
// Purpose: Synchrocheck supervision with three stages and automatic closing
// Assumes: Measurements refreshed every 5 ms; APB slave registers
// Notes:   All decisions are taken on the processing tick only
//
// Behaviour
// - One synchro-side input: stage one compares it to chosen phase/line voltage; others off.
// - Both synchro-side: stage one third, stage two fourth, stage three third versus fourth.
// - Synchronised only when magnitude, frequency and angle differences are within limits.
// - Each side is live or dead from live and dead thresholds.
// - Selected live/dead combinations are additionally required before synchronised.
// - Uses frequency, angle and magnitude, refreshed on a 5 ms time base.
// - Per-stage state: blocked, ok, bypass, voltage, magnitude, angle, frequency ok.
// - Voltage status: dead-dead, live-dead, dead-live, live-live, undefined, unmonitored.
// - Magnitude difference reported in 0.01 %Un.
// - Angle difference reported in 0.01 degree.
// - Frequency difference reported, plus or minus 75 Hz.
// - With auto close, switching status still, departing or enclosing is shown.
// - Network placement angle reported in 0.001 degree.
// - Block input sampled once per processing cycle, one clock before the processing tick.
// - Synchronised and not blocked gives the synchronisation-OK output.
// - Block active when OK would assert gives blocked output instead, held while block stays active.
// - An OK already asserted is cleared when blocking occurs.
// - With auto close, a close command is issued once synchronised.
// - On-start mode checks only while stage start input is active.
// - Breaker delay in 5 ms steps advances the close command.
//
// Design decisions made here: the APB slave port and the register addresses.
`default_nettype none
module syc_top
    import syc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = SYC_TICK_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire syc_meas_t   phase_meas_i [3],
    input  wire syc_meas_t   line_meas_i [3],
    input  wire syc_meas_t   third_voltage_input_i,
    input  wire syc_meas_t   fourth_voltage_input_i,
    input  wire logic        block_i,
    input  wire logic [2:0]  stage_start_input_i,
    output logic      [2:0]  sync_satisfied_output_o,
    output logic      [2:0]  blocked_o,
    output logic             breaker_close_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and processing tick
    logic        rst_s1_q;
    logic        rst_n_q;
    logic [19:0] tick_cnt_q;
    logic        tick;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    assign tick = (tick_cnt_q == 20'(TICK_CYCLES - 1));

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tick_cnt_q <= 20'h00000;
        end else begin
            tick_cnt_q <= tick ? 20'h00000 : tick_cnt_q + 20'h00001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0] ctrl_q;
    logic [15:0] lim_mag_q;
    logic [15:0] lim_ang_q;
    logic [15:0] lim_frq_q;
    logic [31:0] thresh_q;
    logic [11:0] vcond_q;
    logic [15:0] brkdly_q;
    logic        ss3;
    logic        ss4;
    logic        both_ss;
    logic        auto_en;

    assign ss3     = ctrl_q[SYC_CTRL_SS3];
    assign ss4     = ctrl_q[SYC_CTRL_SS4];
    assign both_ss = ss3 & ss4;
    assign auto_en = ctrl_q[SYC_CTRL_AUTO];

    // Picks the reference voltage named by a selection code
    function automatic syc_meas_t pick_ref(input logic [2:0] code, input syc_meas_t ph [3],
                                           input syc_meas_t ln [3]);
        syc_meas_t m;
        m = '0;
        case (code)
            SYC_REF_AB: m = ln[0];
            SYC_REF_BC: m = ln[1];
            SYC_REF_CA: m = ln[2];
            SYC_REF_A:  m = ph[0];
            SYC_REF_B:  m = ph[1];
            SYC_REF_C:  m = ph[2];
            default:    m = '0;
        endcase
        return m;
    endfunction

    function automatic logic [31:0] abs32(input logic signed [31:0] v);
        return v[31] ? 32'(-v) : 32'(v);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Stage sources
    syc_meas_t   ref_m [3];
    syc_meas_t   syn_m [3];
    logic [2:0]  stage_act;
    logic [2:0]  ref1_code;
    logic [2:0]  ref2_code;

    assign ref1_code = ctrl_q[SYC_CTRL_REF1 +: 3];
    // Second stage takes line voltages only; phase codes mean not in use
    assign ref2_code = ctrl_q[SYC_CTRL_REF2 + 2] ? 3'h0 : ctrl_q[SYC_CTRL_REF2 +: 3];

    assign ref_m[0] = pick_ref(both_ss && ref1_code[2] ? 3'h0 : ref1_code,
                               phase_meas_i, line_meas_i);
    assign syn_m[0] = ss3 ? third_voltage_input_i : fourth_voltage_input_i;
    assign ref_m[1] = pick_ref(ref2_code, phase_meas_i, line_meas_i);
    assign syn_m[1] = fourth_voltage_input_i;
    assign ref_m[2] = third_voltage_input_i;
    assign syn_m[2] = fourth_voltage_input_i;

    assign stage_act[0] = (ss3 | ss4) & ctrl_q[SYC_CTRL_USE] & (ref1_code != 3'h0)
                          & !(both_ss & ref1_code[2]);
    assign stage_act[1] = both_ss & ctrl_q[SYC_CTRL_USE + 1] & (ref2_code != 3'h0);
    assign stage_act[2] = both_ss & ctrl_q[SYC_CTRL_USE + 2] & ctrl_q[SYC_CTRL_REF3];

    ////////////////////////////////////////////////////////////////////////////
    // Per-stage evaluation
    logic signed [31:0] mag_d  [3];
    logic signed [31:0] frq_d  [3];
    logic signed [31:0] ang_d  [3];
    logic [2:0]         sat;
    logic [6:0]         rep    [3];
    syc_vstat_t         vs     [3];
    logic [2:0]         started;
    logic               blk_q;
    logic [2:0]         ok_q;
    logic [2:0]         blkd_q;
    logic [6:0]         rep_q  [3];
    syc_vstat_t         vs_q   [3];
    logic signed [31:0] magr_q [3];
    logic signed [31:0] angr_q [3];
    logic signed [31:0] frqr_q [3];

    genvar s;
    generate
        for (s = 0; s < 3; s++) begin : g_stage
            logic signed [31:0] raw_ang;
            logic               ref_live;
            logic               ref_dead;
            logic               syn_live;
            logic               syn_dead;
            logic               mag_ok;
            logic               ang_ok;
            logic               frq_ok;
            logic               vc_ok;

            assign mag_d[s] = 32'(signed'({16'h0000, syn_m[s].mag}))
                              - 32'(signed'({16'h0000, ref_m[s].mag}));
            assign frq_d[s] = 32'(signed'({16'h0000, syn_m[s].frq}))
                              - 32'(signed'({16'h0000, ref_m[s].frq}));
            assign raw_ang  = 32'(signed'({16'h0000, ref_m[s].ang}))
                              - 32'(signed'({16'h0000, syn_m[s].ang}));
            // Shortest way round, so 359 deg against 1 deg reads as 2 deg
            assign ang_d[s] = (raw_ang >  SYC_HALF_TURN) ? raw_ang - SYC_FULL_TURN :
                              (raw_ang < -SYC_HALF_TURN) ? raw_ang + SYC_FULL_TURN :
                              raw_ang;

            assign ref_live = ref_m[s].mag >= thresh_q[15:0];
            assign ref_dead = ref_m[s].mag <= thresh_q[SYC_THR_DEAD +: 16];
            assign syn_live = syn_m[s].mag >= thresh_q[15:0];
            assign syn_dead = syn_m[s].mag <= thresh_q[SYC_THR_DEAD +: 16];

            assign vs[s] = !stage_act[s]          ? SYC_VS_NONE :
                           (ref_dead & syn_dead)  ? SYC_VS_DD   :
                           (ref_live & syn_dead)  ? SYC_VS_LD   :
                           (ref_dead & syn_live)  ? SYC_VS_DL   :
                           (ref_live & syn_live)  ? SYC_VS_LL   : SYC_VS_UNDEF;

            assign vc_ok  = (vs[s] != SYC_VS_NONE) && (vs[s] != SYC_VS_UNDEF)
                            && vcond_q[4 * s + 32'(vs[s]) - 1];
            assign mag_ok = abs32(mag_d[s]) <= {16'h0000, lim_mag_q};
            assign ang_ok = abs32(ang_d[s]) <= {16'h0000, lim_ang_q};
            assign frq_ok = abs32(frq_d[s]) <= {16'h0000, lim_frq_q};
            assign started[s] = !ctrl_q[SYC_CTRL_ONSTART + s] | stage_start_input_i[s];
            assign sat[s] = stage_act[s] & started[s] & mag_ok & ang_ok & frq_ok & vc_ok;

            assign rep[s] = {frq_ok, ang_ok, mag_ok, vc_ok, !stage_act[s],
                             sat[s] & !blk_q, sat[s] & blk_q};

            always_ff @(posedge clk_i or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    ok_q[s]   <= 1'b0;
                    blkd_q[s] <= 1'b0;
                    rep_q[s]  <= 7'h00;
                    vs_q[s]   <= SYC_VS_NONE;
                    magr_q[s] <= 32'h0000_0000;
                    angr_q[s] <= 32'h0000_0000;
                    frqr_q[s] <= 32'h0000_0000;
                end else if (tick) begin
                    // Once blocked the stage holds until the block input drops
                    blkd_q[s] <= blk_q & (blkd_q[s] | sat[s]);
                    ok_q[s]   <= sat[s] & !blk_q;
                    rep_q[s]  <= rep[s];
                    vs_q[s]   <= vs[s];
                    magr_q[s] <= mag_d[s];
                    angr_q[s] <= ang_d[s];
                    frqr_q[s] <= frq_d[s];
                end
            end
        end
    endgenerate

    // Sampled exactly once per processing cycle, one clock ahead of the decision
    logic tick_pre;
    assign tick_pre = (tick_cnt_q == 20'(TICK_CYCLES - 2)) | (TICK_CYCLES < 2);

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            blk_q <= 1'b0;
        end else if (tick_pre) begin
            blk_q <= block_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Automatic closing on stage one
    logic signed [47:0] pred;
    logic signed [47:0] pred_abs;
    logic               aim_ok;
    logic               closed_q;
    logic               close_q;
    syc_sw_t            sw;

    // Angle expected when contacts meet, in 0.001 deg
    assign pred     = 48'(ang_d[0]) * SYC_PLACE_SCALE
                      - 48'(frq_d[0]) * 48'(signed'({16'h0000, brkdly_q})) * SYC_SLIP_MDEG;
    assign pred_abs = pred[47] ? -pred : pred;
    assign aim_ok   = pred_abs <= 48'(lim_ang_q) * SYC_PLACE_SCALE;

    assign sw = !auto_en                    ? SYC_SW_OFF   :
                (frq_d[0] == 0)             ? SYC_SW_STILL :
                (ang_d[0][31] == frq_d[0][31] && ang_d[0] != 0) ? SYC_SW_ENC : SYC_SW_DEP;

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            closed_q <= 1'b0;
            close_q  <= 1'b0;
        end else begin
            // One command per synchronised episode; rearms when OK drops
            close_q  <= tick & auto_en & ok_q[0] & aim_ok & !closed_q;
            if (tick) begin
                closed_q <= ok_q[0] & (closed_q | (auto_en & aim_ok));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: two-cycle access, write lands on the pready edge
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_mux;
    logic        hit;
    logic        wr_en;
    logic [1:0]  dsel;

    assign dsel  = ctrl_q[SYC_CTRL_DSEL +: 2];
    assign wr_en = psel_i & penable_i & pready_q & pwrite_i & hit;
    assign hit   = (paddr_i[1:0] == 2'b00) && (paddr_i <= SYC_OFF_PLACE);

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr_i)
            SYC_OFF_CTRL:    rd_mux = ctrl_q;
            SYC_OFF_LIM_MAG: rd_mux = {16'h0000, lim_mag_q};
            SYC_OFF_LIM_ANG: rd_mux = {16'h0000, lim_ang_q};
            SYC_OFF_LIM_FRQ: rd_mux = {16'h0000, lim_frq_q};
            SYC_OFF_THRESH:  rd_mux = thresh_q;
            SYC_OFF_VCOND:   rd_mux = {20'h00000, vcond_q};
            SYC_OFF_BRKDLY:  rd_mux = {16'h0000, brkdly_q};
            SYC_OFF_STATE:   rd_mux = {9'h000, rep_q[2], 1'b0, rep_q[1], 1'b0, rep_q[0]};
            SYC_OFF_VSTAT:   rd_mux = {18'h00000, sw, 1'b0, vs_q[2], 1'b0, vs_q[1],
                                       1'b0, vs_q[0]};
            SYC_OFF_MAGDIFF: rd_mux = magr_q[dsel == 2'h3 ? 2'h0 : dsel];
            SYC_OFF_ANGDIFF: rd_mux = angr_q[dsel == 2'h3 ? 2'h0 : dsel];
            SYC_OFF_FRQDIFF: rd_mux = frqr_q[dsel == 2'h3 ? 2'h0 : dsel];
            SYC_OFF_PLACE:   rd_mux = 32'(angr_q[dsel == 2'h3 ? 2'h0 : dsel] * SYC_PLACE_SCALE);
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel_i & penable_i & !pready_q;
            pslverr_q <= psel_i & penable_i & !pready_q & !hit;
            prdata_q  <= (psel_i & penable_i & !pready_q & !pwrite_i) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q    <= SYC_RST_CTRL;
            lim_mag_q <= SYC_RST_LIM;
            lim_ang_q <= SYC_RST_LIM;
            lim_frq_q <= SYC_RST_LIM;
            thresh_q  <= SYC_RST_THRESH;
            vcond_q   <= SYC_RST_VCOND;
            brkdly_q  <= SYC_RST_BRKDLY;
        end else if (wr_en) begin
            // Software must give stages one and two one reference over three breakers
            if (paddr_i == SYC_OFF_CTRL)    ctrl_q    <= pwdata_i;
            if (paddr_i == SYC_OFF_LIM_MAG) lim_mag_q <= pwdata_i[15:0];
            if (paddr_i == SYC_OFF_LIM_ANG) lim_ang_q <= pwdata_i[15:0];
            if (paddr_i == SYC_OFF_LIM_FRQ) lim_frq_q <= pwdata_i[15:0];
            if (paddr_i == SYC_OFF_THRESH)  thresh_q  <= pwdata_i;
            if (paddr_i == SYC_OFF_VCOND)   vcond_q   <= pwdata_i[11:0];
            if (paddr_i == SYC_OFF_BRKDLY)  brkdly_q  <= pwdata_i[15:0];
        end
    end

    assign prdata_o                = prdata_q;
    assign pready_o                = pready_q;
    assign pslverr_o               = pslverr_q;
    assign sync_satisfied_output_o = ok_q;
    assign blocked_o               = blkd_q;
    assign breaker_close_o         = close_q;

endmodule
`default_nettype wire

// [verif/syc_meas_model.sv]
// Purpose: Measurement front end feeding the synchrocheck block
// Assumes: One refresh every REFRESH clocks
// Notes:   skew_i drops the third input magnitude and lifts its frequency by 0.5 Hz
`default_nettype none
module syc_meas_model
    import syc_pkg::*;
#(
    parameter int unsigned REFRESH = 20
) (
    input  wire logic      clk_i,
    input  wire logic      skew_i,
    output var syc_meas_t  phase_o [3],
    output var syc_meas_t  line_o [3],
    output var syc_meas_t  third_o,
    output var syc_meas_t  fourth_o
);
    int unsigned cnt_q  = 0;
    logic        skew_q = 1'b0;
    // A change of skew only shows on a refresh boundary
    always @(posedge clk_i) begin
        cnt_q <= (cnt_q == REFRESH - 1) ? 0 : cnt_q + 1;
        if (cnt_q == 0) begin
            skew_q <= skew_i;
        end
    end
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            phase_o[i] = '{16'd5774, 16'd5000, 16'(i * 12000)};
            line_o[i]  = '{16'd10000, 16'd5000, 16'(i * 12000)};
        end
        third_o  = '{(skew_q ? 16'd5000 : 16'd10000), (skew_q ? 16'd5050 : 16'd5000), 16'd0};
        fourth_o = '{16'd10000, 16'd5000, 16'd0};
    end
endmodule
`default_nettype wire

// [verif/syc_monitor.sv]
// Purpose: Port assertions for the synchrocheck block
// Assumes: One clock, resetn_i active low
// Notes:   Block input is taken one clock before the tick
`default_nettype none
module syc_monitor (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        block_i,
    input wire logic [2:0]  sync_satisfied_output_o,
    input wire logic [2:0]  blocked_o,
    input wire logic        breaker_close_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_ok_blk_excl: assert property ((sync_satisfied_output_o & blocked_o) == 3'h0)
        else $error("ok and blocked together");
    a_ok_tick_hold: assert property ($changed(sync_satisfied_output_o) |=> $stable(sync_satisfied_output_o)[*8])
        else $error("ok moved between ticks");
    a_blk_tick_hold: assert property ($changed(blocked_o) |=> $stable(blocked_o)[*8])
        else $error("blocked moved between ticks");
    a_ok_rise_free: assert property ($rose(sync_satisfied_output_o[0]) |-> !$past(block_i, 2))
        else $error("ok rose while blocking");
    a_blk_rise_cause: assert property ($rose(blocked_o[0]) |-> $past(block_i, 2))
        else $error("blocked rose without block");
    a_blk_fall_cause: assert property ($fell(blocked_o[0]) |-> !$past(block_i, 2))
        else $error("blocked fell while block held");
    a_close_one_pulse: assert property (breaker_close_o |=> !breaker_close_o)
        else $error("close longer than one cycle");
    a_close_after_ok: assert property (breaker_close_o |-> ($past(sync_satisfied_output_o[0]) ||
                                        $past(sync_satisfied_output_o[0], 2)))
        else $error("close without ok");
    a_apb_ready_next: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("no ready after access");
    a_apb_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside ready");
    c_blocked: cover property ($rose(blocked_o[0]));
    c_close: cover property (breaker_close_o);
    c_slverr: cover property (pslverr_o);
endmodule
bind syc_top syc_monitor mon_u (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .block_i(block_i),
    .sync_satisfied_output_o(sync_satisfied_output_o), .blocked_o(blocked_o), .breaker_close_o(breaker_close_o));
`default_nettype wire

// [verif/syc_top_tb_top.sv]
// Purpose: Directed bench for the synchrocheck block
// Assumes: Short processing tick of 20 clocks
// Notes:   Waits are counted in ticks because outputs move only there
`default_nettype none
module syc_top_tb_top;
    import syc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 20;
    `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
    logic clk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, block_i = 0, skew = 0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic pready_o, pslverr_o, breaker_close_o, er;
    logic [2:0] stage_start_input_i = 3'h0, sync_satisfied_output_o, blocked_o;
    syc_meas_t ph [3], ln [3], u3, u4;
    int bad_count = 0, n_compared = 0, n_close = 0;
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (breaker_close_o === 1'b1) n_close++;
    syc_meas_model #(.REFRESH(T)) pm_u (.clk_i(clk_i), .skew_i(skew), .phase_o(ph), .line_o(ln),
        .third_o(u3), .fourth_o(u4));
    syc_top #(.TICK_CYCLES(T)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .phase_meas_i(ph),
        .line_meas_i(ln), .third_voltage_input_i(u3), .fourth_voltage_input_i(u4), .block_i(block_i),
        .stage_start_input_i(stage_start_input_i), .sync_satisfied_output_o(sync_satisfied_output_o),
        .blocked_o(blocked_o), .breaker_close_o(breaker_close_o));
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
        @(posedge clk_i) penable_i <= 1'b1;
        // No cycle budget here: a slave that never answers is caught by the watchdog
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0; penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic ticks(input int k);
        repeat (k * T) @(posedge clk_i);
    endtask
    task automatic finish_test();
        $display("compared=%0d mismatches=%0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        apb(0, SYC_OFF_CTRL, 0); `CHK(rd, SYC_RST_CTRL)
        apb(0, SYC_OFF_BRKDLY, 0); `CHK(rd[15:0], 16'h000a)
        apb(0, 8'h40, 0); `CHK(er, 1'b1)
        $display("test registers end");
        apb(1, SYC_OFF_LIM_MAG, 32'd500); apb(1, SYC_OFF_LIM_ANG, 32'd1000); apb(1, SYC_OFF_LIM_FRQ, 32'd100);
        apb(1, SYC_OFF_THRESH, 32'h07d0_1f40); apb(1, SYC_OFF_VCOND, 32'h888);
        // Stages two and three are switched on too; one synchro-side input must keep them off
        apb(1, SYC_OFF_CTRL, 32'h931d);
        ticks(5);
        `CHK(sync_satisfied_output_o, 3'b001)
        `CHK(n_close, 1)
        apb(0, SYC_OFF_STATE, 0); `CHK(rd[6:0], 7'h7a)
        `CHK(rd[10], 1'b1)
        apb(0, SYC_OFF_VSTAT, 0); `CHK(rd[2:0], 3'h4)
        `CHK(rd[13:12], 2'h1)
        $display("test sync end");
        block_i <= 1'b1; ticks(2);
        `CHK(sync_satisfied_output_o, 3'b000)
        `CHK(blocked_o, 3'b001)
        block_i <= 1'b0; ticks(2);
        `CHK(blocked_o, 3'b000)
        skew <= 1'b1; ticks(3);
        `CHK(sync_satisfied_output_o, 3'b000)
        apb(0, SYC_OFF_MAGDIFF, 0); `CHK(rd[15:0], 16'hec78)
        apb(0, SYC_OFF_FRQDIFF, 0); `CHK(rd[15:0], 16'h0032)
        $display("test block end");
        skew <= 1'b0;
        // Reference ca sits 240 deg ahead, so the shortest way round is -120 deg
        apb(1, SYC_OFF_CTRL, 32'h705);
        ticks(2);
        apb(0, SYC_OFF_ANGDIFF, 0); `CHK(rd, 32'hffffd120)
        apb(0, SYC_OFF_PLACE, 0); `CHK(rd, 32'hfffe2b40)
        $display("test angle end");
        apb(1, SYC_OFF_CTRL, 32'h923f);
        ticks(4);
        `CHK(sync_satisfied_output_o, 3'b110)
        stage_start_input_i <= 3'b001; ticks(3);
        `CHK(sync_satisfied_output_o, 3'b111)
        $display("test dual end");
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        bad_count++;
        finish_test();
    end
endmodule
`default_nettype wire
